// ---- bench/nonvolatile_backed_sram_port_tb.sv ----
// Self-checking bench for the host controller of the nonvolatile-backed static RAM.
// Assumes the pin model nv_sram_dev and a 20 MHz clock.
`timescale 1ns/1ps

module nonvolatile_backed_sram_port_tb;
	logic                   clock = 1'b0;
	logic                   arst_n = 1'b0;
	logic                   req_valid = 1'b0;
	nv_sram_host_pkg::cmd_t req_cmd = '0;
	nv_sram_host_pkg::rsp_t rsp;
	logic                   req_ready, data_lines_oe, chip_select_n, write_strobe_n;
	logic                   output_enable_n, store_busy_n_o, store_busy_n_oe;
	logic                   dev_oe, dev_sb_o, dev_sb_oe, sb;
	logic                   power_good = 1'b1;
	logic [14:0]            byte_address, a;
	logic [7:0]             data_lines_o, dev_d, dq;
	logic [7:0]             ram [logic [14:0]];
	logic [8:0]             note [$];
	logic [8:0]             e;
	logic [31:0]            seed = 32'h8617;
	int                     fail_count = 0;
	int                     comparisons = 0;

	always #25 clock = ~clock;
	assign dq = data_lines_oe ? data_lines_o : dev_d;
	assign sb = ((store_busy_n_oe && !store_busy_n_o) || (dev_sb_oe && !dev_sb_o)) ? 1'b0 : 1'b1;

	nv_sram_host dut (.clock, .arst_n, .req_valid, .req_cmd, .req_ready, .rsp, .byte_address,
		.data_lines_i(dq), .data_lines_o, .data_lines_oe, .chip_select_n, .write_strobe_n,
		.output_enable_n, .store_busy_n_i(sb), .store_busy_n_o, .store_busy_n_oe);

	nv_sram_dev dev (.byte_address, .data_lines_i(dq), .data_lines_o(dev_d),
		.data_lines_oe(dev_oe), .chip_select_n, .write_strobe_n, .output_enable_n,
		.store_busy_n_i(sb), .store_busy_n_o(dev_sb_o), .store_busy_n_oe(dev_sb_oe), .power_good);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input string w, input logic [7:0] x, input logic [7:0] s);
		comparisons++;
		if (s !== x) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", w, x, s);
		end
	endtask

	// Notes the expected answer, then holds the request until the ready drop shows acceptance.
	task automatic go(input logic [2:0] o, input logic [14:0] ad, input logic [7:0] d,
		input logic [8:0] x);
		logic prev;
		note.push_back(x);
		@(posedge clock);
		req_valid <= 1'b1;
		req_cmd <= '{nv_sram_host_pkg::op_t'(o), ad, d};
		#1;
		prev = req_ready;
		for (int n = 0; n < 1000; n++) begin
			@(posedge clock);
			#1;
			if (prev && !req_ready)
				break;
			prev = req_ready;
		end
		@(posedge clock);
		req_valid <= 1'b0;
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		check("drive clash", 8'h00, {7'h00, data_lines_oe && (!output_enable_n || dev_oe)});
		if (rsp.done === 1'b1) begin
			if (note.size() == 0) begin
				check("spare done", 8'h00, 8'h01);
			end else begin
				e = note.pop_front();
				if (e[8])
					check("read data", e[7:0], rsp.rdata);
			end
		end
	end

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7fff : seed[14:0];
			ram[a] = seed[22:15];
			go(3'd1, a, seed[22:15], 9'h000);
		end
		foreach (ram[k])
			go(3'd0, k, 8'h00, {1'b1, ram[k]});
		go(3'd1, 15'h1234, 8'ha5, 9'h000);
		go(3'd3, 15'h0000, 8'h00, 9'h000);
		go(3'd1, 15'h1234, 8'h3c, 9'h000);
		go(3'd0, 15'h1234, 8'h00, 9'h13c);
		go(3'd4, 15'h0000, 8'h00, 9'h000);
		go(3'd0, 15'h1234, 8'h00, 9'h1a5);
		go(3'd1, 15'h1234, 8'h69, 9'h000);
		go(3'd2, 15'h0000, 8'h00, 9'h000);
		go(3'd1, 15'h1234, 8'h00, 9'h000);
		go(3'd4, 15'h0000, 8'h00, 9'h000);
		go(3'd0, 15'h1234, 8'h00, 9'h169);
		// Nothing written since the recall, so the device skips this save.
		go(3'd2, 15'h0000, 8'h00, 9'h000);
		go(3'd1, 15'h0777, 8'h5e, 9'h000);
		wait (note.size() == 0);
		@(posedge clock);
		power_good <= 1'b0;
		repeat (50) @(posedge clock);
		power_good <= 1'b1;
		go(3'd0, 15'h0777, 8'h00, 9'h15e);
		wait (note.size() == 0);
		// A second reset in mid-run; the device keeps its contents.
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		go(3'd0, 15'h0777, 8'h00, 9'h15e);
		wait (note.size() == 0);
		repeat (4) @(posedge clock);
		close_out();
	end

	// The scenarios take a few hundred cycles; this limit leaves ample margin.
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		close_out();
	end
endmodule // nonvolatile_backed_sram_port_tb

// ---- bench/nv_sram_dev.sv ----
// Behavioural pin model of the nonvolatile-backed 32K x 8 static RAM.
// Assumes the bench resolves the shared data wire from the host enable alone and the store-busy wire from both enables.
`timescale 1ns/1ps

module nv_sram_dev (
	input  wire logic [14:0] byte_address,
	input  wire logic [7:0]  data_lines_i,
	output logic [7:0]       data_lines_o,
	output logic             data_lines_oe,
	input  wire logic        chip_select_n,
	input  wire logic        write_strobe_n,
	input  wire logic        output_enable_n,
	input  wire logic        store_busy_n_i,
	output logic             store_busy_n_o = 1'b1,
	output logic             store_busy_n_oe = 1'b0,
	input  wire logic        power_good
);
	logic [7:0]  mem_q [32768];
	logic [7:0]  nv_q  [32768];
	logic [14:0] seq_q [6] = '{15'h0e38, 15'h31c7, 15'h03e0, 15'h3c1f, 15'h303f, 15'h0fc0};
	logic        dirty_q = 1'b0;
	logic        busy_q = 1'b0;
	int          step_q = 0;

	// Released lines show the inverse of the addressed byte so stale data cannot pass.
	assign data_lines_oe = !chip_select_n && !output_enable_n && write_strobe_n
		&& !busy_q;
	assign data_lines_o = data_lines_oe ? mem_q[byte_address] : ~mem_q[byte_address];

	task automatic save(input bit forced);
		if (forced || dirty_q) begin
			busy_q = 1'b1;
			store_busy_n_o = 1'b0;
			store_busy_n_oe = 1'b1;
			#1500;
			nv_q = mem_q;
			dirty_q = 1'b0;
			store_busy_n_o = 1'b1;
			#100;
			store_busy_n_oe = 1'b0;
			busy_q = 1'b0;
		end
	endtask

	// Evaluated a moment after the pins move, so strobes, address and data are seen settled.
	always @(chip_select_n, write_strobe_n, byte_address, data_lines_i) begin
		#1;
		if (!chip_select_n && !write_strobe_n && !busy_q) begin
			mem_q[byte_address] = data_lines_i;
			dirty_q = 1'b1;
			step_q = 0;
		end
	end

	always @(negedge output_enable_n) begin
		#1;
		if (!chip_select_n && write_strobe_n && !busy_q) begin
			if (step_q == 5 && byte_address == 15'h0c63) begin
				mem_q = nv_q;
				dirty_q = 1'b0;
				step_q = 0;
			end else if (byte_address == seq_q[step_q]) begin
				step_q++;
				if (step_q == 6) begin
					step_q = 0;
					save(1'b1);
				end
			end else begin
				step_q = (byte_address == seq_q[0]) ? 1 : 0;
			end
		end
	end

	always @(negedge store_busy_n_i)
		if (!busy_q) begin
			#10;
			save(1'b0);
		end

	always @(negedge power_good) begin
		save(1'b0);
		foreach (mem_q[i])
			mem_q[i] = 8'h00;
	end

	always @(posedge power_good) begin
		mem_q = nv_q;
		dirty_q = 1'b0;
	end
endmodule // nv_sram_dev

// ---- rtl/nv_sram_host.sv ----
// Host controller that drives a nonvolatile-backed 32K x 8 static RAM through its pins.
// Assumes the testbench resolves the two-way data and store-busy wires from the enables.
//
// Operation
// - Host presents 15-bit byte address per access.
// - Data lines carry writes out, reads in.
// - Host pulls store-busy low to request save.
// - Host may start save or restore by software.
// - Software save: six ordered reads, 0e38..0fc0.
`timescale 1ns/1ps

module nv_sram_host (
	input  wire logic                                clock,
	input  wire logic                                arst_n,
	input  wire logic                                req_valid,
	input  wire nv_sram_host_pkg::cmd_t              req_cmd,
	output logic                                     req_ready,
	output nv_sram_host_pkg::rsp_t                   rsp,
	output logic [nv_sram_host_pkg::ADDR_W-1:0]      byte_address,
	input  wire logic [nv_sram_host_pkg::DATA_W-1:0] data_lines_i,
	output logic [nv_sram_host_pkg::DATA_W-1:0]      data_lines_o,
	output logic                                     data_lines_oe,
	output logic                                     chip_select_n,
	output logic                                     write_strobe_n,
	output logic                                     output_enable_n,
	input  wire logic                                store_busy_n_i,
	output logic                                     store_busy_n_o,
	output logic                                     store_busy_n_oe
);

	// ------------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0]                            rst_q;
	logic                                  rst_n;
	logic [nv_sram_host_pkg::DATA_W-1:0]   din_meta_q;
	logic [nv_sram_host_pkg::DATA_W-1:0]   din_q;
	logic                                  busy_meta_q;
	logic                                  busy_n_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			din_meta_q  <= 8'h00;
			din_q       <= 8'h00;
			busy_meta_q <= 1'b1;
			busy_n_q    <= 1'b1;
		end else begin
			din_meta_q  <= data_lines_i;
			din_q       <= din_meta_q;
			busy_meta_q <= store_busy_n_i;
			busy_n_q    <= busy_meta_q;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE, S_RD_ACC, S_RD_GAP, S_WR_PULSE, S_WR_REC, S_HW_PULL, S_BUSY_WAIT
	} state_t;

	state_t                                state_q, state_d;
	logic [nv_sram_host_pkg::CNT_W-1:0]    cnt_q, cnt_d;
	logic [2:0]                            idx_q, idx_d;
	logic                                  seq_q, seq_d;
	logic                                  recall_q, recall_d;
	nv_sram_host_pkg::cmd_t                cmd_q, cmd_d;
	logic                                  accept;
	logic                                  finish;

	// Requests wait while the device signals a save or restore.
	assign accept = req_valid && req_ready && busy_n_q;

	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		idx_d    = idx_q;
		seq_d    = seq_q;
		recall_d = recall_q;
		cmd_d    = cmd_q;
		finish   = 1'b0;
		if (cnt_q != '0) begin
			cnt_d = cnt_q - 5'h01;
		end
		unique case (state_q)
			S_IDLE: begin
				if (accept) begin
					cmd_d    = req_cmd;
					idx_d    = 3'h0;
					seq_d    = (req_cmd.op == nv_sram_host_pkg::OP_SW_STORE) ||
					           (req_cmd.op == nv_sram_host_pkg::OP_SW_RECALL);
					recall_d = req_cmd.op == nv_sram_host_pkg::OP_SW_RECALL;
					unique case (req_cmd.op)
						nv_sram_host_pkg::OP_WRITE: begin
							state_d = S_WR_PULSE;
							cnt_d   = nv_sram_host_pkg::WR_CYC;
						end
						nv_sram_host_pkg::OP_HW_STORE: begin
							state_d = S_HW_PULL;
							cnt_d   = nv_sram_host_pkg::PULL_CYC;
						end
						default: begin
							state_d = S_RD_ACC;
							cnt_d   = nv_sram_host_pkg::RD_CYC;
						end
					endcase
				end
			end
			S_RD_ACC: begin
				if (cnt_q == 5'h01) begin
					state_d = S_RD_GAP;
				end
			end
			S_RD_GAP: begin
				// Back-to-back sequence reads with one deselected cycle between them.
				if (seq_q && idx_q != nv_sram_host_pkg::SEQ_LAST_IDX) begin
					idx_d   = idx_q + 3'h1;
					state_d = S_RD_ACC;
					cnt_d   = nv_sram_host_pkg::RD_CYC;
				end else if (seq_q) begin
					state_d = S_BUSY_WAIT;
					cnt_d   = nv_sram_host_pkg::GUARD_CYC;
				end else begin
					state_d = S_IDLE;
					finish  = 1'b1;
				end
			end
			S_WR_PULSE: begin
				if (cnt_q == 5'h01) begin
					state_d = S_WR_REC;
				end
			end
			S_WR_REC: begin
				state_d = S_IDLE;
				finish  = 1'b1;
			end
			S_HW_PULL: begin
				if (cnt_q == 5'h01) begin
					state_d = S_BUSY_WAIT;
					cnt_d   = nv_sram_host_pkg::GUARD_CYC;
				end
			end
			S_BUSY_WAIT: begin
				// Device may skip the save; the guard covers its start delay.
				if (cnt_q == '0 && busy_n_q) begin
					state_d = S_IDLE;
					finish  = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= S_IDLE;
			cnt_q    <= '0;
			idx_q    <= 3'h0;
			seq_q    <= 1'b0;
			recall_q <= 1'b0;
			cmd_q    <= '0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			idx_q    <= idx_d;
			seq_q    <= seq_d;
			recall_q <= recall_d;
			cmd_q    <= cmd_d;
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers, registered from the next state
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			byte_address    <= '0;
			data_lines_o    <= 8'h00;
			data_lines_oe   <= 1'b0;
			chip_select_n   <= 1'b1;
			write_strobe_n  <= 1'b1;
			output_enable_n <= 1'b1;
			store_busy_n_o  <= 1'b1;
			store_busy_n_oe <= 1'b0;
		end else begin
			if (state_d == S_RD_ACC && seq_d) begin
				byte_address <= nv_sram_host_pkg::seq_addr(idx_d, recall_d);
			end else if (state_d == S_RD_ACC || state_d == S_WR_PULSE) begin
				byte_address <= cmd_d.addr;
			end
			chip_select_n   <= !(state_d == S_RD_ACC || state_d == S_WR_PULSE);
			output_enable_n <= state_d != S_RD_ACC;
			write_strobe_n  <= state_d != S_WR_PULSE;
			// Data is held one cycle past the strobe to cover the device hold time.
			data_lines_oe   <= state_d == S_WR_PULSE || state_d == S_WR_REC;
			data_lines_o    <= cmd_d.wdata;
			store_busy_n_o  <= 1'b0;
			store_busy_n_oe <= state_d == S_HW_PULL;
		end
	end

	// ------------------------------------------------------------------
	// Response
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rsp       <= '0;
			req_ready <= 1'b0;
		end else begin
			rsp.done  <= finish;
			req_ready <= state_d == S_IDLE;
			if (state_q == S_RD_ACC && cnt_q == 5'h01 && !seq_q) begin
				rsp.rdata <= din_q;
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence sw_store_start;
		accept && req_cmd.op == nv_sram_host_pkg::OP_SW_STORE;
	endsequence

	sequence first_seq_read;
		!chip_select_n && !output_enable_n && byte_address == nv_sram_host_pkg::SEQ_A0;
	endsequence

	a_idle_deselect: assert property (@(posedge clock) disable iff (!rst_n)
		state_q == S_IDLE |-> chip_select_n)
		else $error("chip select low while idle");
	a_strobes_exclusive: assert property (@(posedge clock) disable iff (!rst_n)
		!(!output_enable_n && (!write_strobe_n || data_lines_oe)))
		else $error("output enable low while host drives data");
	a_write_pulse_len: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(write_strobe_n) |-> (!write_strobe_n && !chip_select_n && data_lines_oe)[*2]
		##1 write_strobe_n)
		else $error("write pulse length wrong");
	a_busy_pull_len: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(store_busy_n_oe) |-> (store_busy_n_oe && !store_busy_n_o)[*4]
		##1 !store_busy_n_oe)
		else $error("store request pull length wrong");
	a_no_access_busy: assert property (@(posedge clock) disable iff (!rst_n)
		state_q == S_IDLE && !busy_n_q |=> chip_select_n)
		else $error("access started while device busy");
	a_sw_store_first: assert property (@(posedge clock) disable iff (!rst_n)
		sw_store_start |=> first_seq_read)
		else $error("software store sequence did not start at first address");
	a_sw_store_last: assert property (@(posedge clock) disable iff (!rst_n)
		state_q == S_RD_ACC && seq_q && !recall_q && idx_q == nv_sram_host_pkg::SEQ_LAST_IDX
		|-> byte_address == nv_sram_host_pkg::STORE_LAST_ADDR)
		else $error("software store sequence last address wrong");
	a_sw_recall_last: assert property (@(posedge clock) disable iff (!rst_n)
		state_q == S_RD_ACC && seq_q && recall_q && idx_q == nv_sram_host_pkg::SEQ_LAST_IDX
		|-> byte_address == nv_sram_host_pkg::RECALL_LAST_ADDR)
		else $error("software recall sequence last address wrong");
	a_seq_no_gap: assert property (@(posedge clock) disable iff (!rst_n)
		state_q == S_RD_GAP && seq_q && idx_q != nv_sram_host_pkg::SEQ_LAST_IDX
		|=> !chip_select_n && !output_enable_n && write_strobe_n)
		else $error("sequence read interrupted");
	a_read_done: assert property (@(posedge clock) disable iff (!rst_n)
		accept && req_cmd.op == nv_sram_host_pkg::OP_READ |-> ##[4:5] rsp.done)
		else $error("read not completed in time");
	a_addr_stable: assert property (@(posedge clock) disable iff (!rst_n)
		!chip_select_n && $past(chip_select_n) == 1'b0 && state_q != S_RD_ACC
		|-> $stable(byte_address))
		else $error("address moved during write");

endmodule // nv_sram_host

// ---- rtl/nv_sram_host_pkg.sv ----
// Package for the host-side controller of a nonvolatile-backed 32K x 8 static RAM.
// Assumes a 20 MHz system clock; every timing count below derives from that rate.
package nv_sram_host_pkg;

	// ------------------------------------------------------------------
	// Widths and clock
	// ------------------------------------------------------------------
	localparam int ADDR_W      = 15;
	localparam int DATA_W      = 8;
	localparam int CNT_W       = 5;
	localparam int CLK_NS      = 50;
	localparam int SEQ_LEN     = 6;

	// ------------------------------------------------------------------
	// Timing: times in ns, counts in cycles (least times round up)
	// ------------------------------------------------------------------
	localparam int ACCESS_NS       = 45;
	localparam int WRITE_PULSE_NS  = 60;
	localparam int BUSY_PULL_NS    = 200;
	localparam int STORE_GUARD_NS  = 1000;
	localparam int SYNC_STAGES     = 2;

	localparam logic [CNT_W-1:0] RD_CYC    =
		CNT_W'((ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
	localparam logic [CNT_W-1:0] WR_CYC    =
		CNT_W'((WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] PULL_CYC  =
		CNT_W'((BUSY_PULL_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] GUARD_CYC =
		CNT_W'((STORE_GUARD_NS + CLK_NS - 1) / CLK_NS);

	// ------------------------------------------------------------------
	// Software store / recall address sequences
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] SEQ_A0          = 15'h0e38;
	localparam logic [ADDR_W-1:0] SEQ_A1          = 15'h31c7;
	localparam logic [ADDR_W-1:0] SEQ_A2          = 15'h03e0;
	localparam logic [ADDR_W-1:0] SEQ_A3          = 15'h3c1f;
	localparam logic [ADDR_W-1:0] SEQ_A4          = 15'h303f;
	localparam logic [ADDR_W-1:0] STORE_LAST_ADDR = 15'h0fc0;
	localparam logic [ADDR_W-1:0] RECALL_LAST_ADDR = 15'h0c63;
	localparam logic [2:0]        SEQ_LAST_IDX    = 3'h5;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_READ, OP_WRITE, OP_HW_STORE, OP_SW_STORE, OP_SW_RECALL
	} op_t;

	typedef struct packed {
		op_t               op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cmd_t;

	typedef struct packed {
		logic              done;
		logic [DATA_W-1:0] rdata;
	} rsp_t;

	function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx, input logic recall);
		logic [ADDR_W-1:0] a;
		a = SEQ_A0;
		unique case (idx)
			3'h0: a = SEQ_A0;
			3'h1: a = SEQ_A1;
			3'h2: a = SEQ_A2;
			3'h3: a = SEQ_A3;
			3'h4: a = SEQ_A4;
			default: a = recall ? RECALL_LAST_ADDR : STORE_LAST_ADDR;
		endcase
		return a;
	endfunction

endpackage
